//--- rtl/cmsp_consts.svh
// Constants for the core reset and memory space block
`ifndef CMSP_CONSTS_SVH
`define CMSP_CONSTS_SVH

// Program counter start value after any reset
`define CMSP_RESET_PC 16'h0000
// Physical regions seen through the program and external data spaces
`define CMSP_FLASH_LO 16'h0000
`define CMSP_FLASH_HI 16'h7FFF
`define CMSP_PERIPH_LO 16'hDF80
`define CMSP_PERIPH_HI 16'hDFFF
`define CMSP_SRAM_LO 16'hF000
`define CMSP_SRAM_HI 16'hFFFF
// Internal data space sits in the top page of SRAM
`define CMSP_INT_PAGE 8'hFF
// Address bit that marks the indirect-only upper half of internal data
`define CMSP_INT_UPPER_BIT 7
// Special function space address width and its offset on the internal port
`define CMSP_SPECIAL_AW 7
`define CMSP_SPECIAL_BASE 9'h001
// Bit-addressable registers sit on multiples of eight
`define CMSP_BIT_ALIGN_MASK 3'h7
// Shared-bus cycles taken by one program or external data access
`define CMSP_EXT_CYCLES 3'h4
// Stretch count loaded by each source; the combined reset stays on for this count plus one cycles after its last source goes away
`define CMSP_RST_HOLD 4'h4
// Reset cause encodings
`define CMSP_CAUSE_POWER 2'h1
`define CMSP_CAUSE_PIN 2'h2
`define CMSP_CAUSE_WATCHDOG 2'h3

`endif

//--- rtl/cmsp_core_mem.sv
// Core reset handling, instruction fetch and memory space decoding
//
// Summary of operation
// RULE1: One clock per instruction cycle, not twelve as in the classic core.
// RULE2: Fetch aligns with instruction cycles; single-byte instructions finish in one clock.
// RULE3: Reset comes from the low reset pin, power-on, or watchdog timeout.
// RULE4: After reset every I/O pin is an input with pull-up connected.
// RULE5: After reset the program counter is zero and execution starts there.
// RULE6: Reset returns every peripheral register to its reset value.
// RULE7: After reset the watchdog stays disabled until software enables it.
// RULE8: Program space has a 16-bit address and is read-only to the core.
// RULE9: Internal data: 8-bit address; upper 128 bytes only indirectly reachable.
// RULE10: External data space: 16-bit read/write, access takes four to five cycles.
// RULE11: Program and external data share one bus; no prefetch during external access.
// RULE12: Special function space: 7-bit direct address; multiples of eight are bit-addressable.
// RULE13: The four spaces overlap so transfers and debugger reach physical memories.
// RULE14: Internal data maps to the top 256 bytes of SRAM, also seen externally.
// RULE15: Peripheral registers also appear in external space, except core-internal ones.
// RULE16: During an external data access fetch stalls and resumes when it completes.
`include "cmsp_consts.svh"
`default_nettype none
module cmsp_core_mem #(
    parameter int GPIO_W = 21,
    parameter logic [127:0] CORE_INTERNAL_MASK = 128'h0
) (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // Reset pin and watchdog
    input wire logic reset_n,
    input wire logic wdt_timeout,
    input wire logic wdt_enable_set,
    output logic wdt_en,
    output logic periph_rst,
    output logic [1:0] rst_cause,
    // I/O pin configuration from software
    input wire logic gpio_cfg_we,
    input wire logic [GPIO_W-1:0] gpio_cfg_oe_n,
    input wire logic [GPIO_W-1:0] gpio_cfg_pull,
    output logic [GPIO_W-1:0] gpio_oe_n,
    output logic [GPIO_W-1:0] gpio_pull,
    // Instruction stream
    input wire logic pc_load,
    input wire logic [15:0] pc_target,
    output logic [15:0] pc,
    output logic fetch_valid,
    output logic [7:0] fetch_data,
    // Data requests from the execution unit
    input wire logic req_valid,
    input wire cmsp_pkg::cmsp_space_t req_space,
    input wire logic req_write,
    input wire logic req_indirect,
    input wire logic req_bit,
    input wire logic [2:0] req_bitpos,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic req_ready,
    output logic rsp_valid,
    output logic rsp_err,
    output logic [7:0] rsp_rdata,
    // Shared program and external data bus
    output logic mem_en,
    output logic mem_we,
    output cmsp_pkg::cmsp_region_t mem_region,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // Internal data and special function port
    output logic int_en,
    output logic int_we,
    output logic int_special,
    output logic int_bit,
    output logic [2:0] int_bitpos,
    output logic [15:0] int_addr,
    output logic [7:0] int_wdata,
    input wire logic [7:0] int_rdata
);
    typedef struct packed {
        cmsp_pkg::cmsp_state_t state;
        logic [15:0] pc;
        logic [2:0] cnt;
        logic [15:0] acc_addr;
        logic acc_we;
        logic [7:0] acc_wdata;
        logic fetch_valid;
        logic [7:0] fetch_data;
        logic rsp_valid;
        logic rsp_err;
        logic [7:0] rsp_rdata;
        logic int_pend;
        logic int_pend_bit;
        logic [2:0] int_pend_pos;
        logic [GPIO_W-1:0] gpio_oe_n;
        logic [GPIO_W-1:0] gpio_pull;
        logic wdt_en;
    } cmsp_mem_state_t;

    cmsp_mem_state_t cur;
    cmsp_mem_state_t next_cur;
    logic sys_rst;
    logic bad_req;
    cmsp_pkg::cmsp_region_t req_region;

    // Map a 16-bit program or external address onto a physical memory
    function automatic cmsp_pkg::cmsp_region_t region_of(input logic [15:0] a);
        cmsp_pkg::cmsp_region_t r;
        r = cmsp_pkg::REGION_NONE;
        if (a <= `CMSP_FLASH_HI) begin
            r = cmsp_pkg::REGION_FLASH; // [RULE13]
        end else if (a >= `CMSP_SRAM_LO) begin
            r = cmsp_pkg::REGION_SRAM; // [RULE14]
        end else if (a >= `CMSP_PERIPH_LO && a <= `CMSP_PERIPH_HI) begin
            // Core-internal registers have no mirror here
            if (!CORE_INTERNAL_MASK[a[`CMSP_SPECIAL_AW-1:0]]) begin
                r = cmsp_pkg::REGION_PERIPH; // [RULE15]
            end
        end
        return r;
    endfunction

    // Reset sources; the watchdog only counts once software has armed it
    cmsp_rst_gen u_rst_gen (
        .mclk(mclk),
        .rst(rst),
        .reset_n(reset_n),
        .wdt_timeout(wdt_timeout & cur.wdt_en),
        .sys_rst(sys_rst),
        .rst_cause(rst_cause)
    );

    // Request checks: program space is read-only, upper internal half is indirect only
    always_comb begin
        req_region = region_of(req_addr);
        bad_req = 1'b0;
        unique case (req_space)
            cmsp_pkg::SPACE_PROGRAM: begin
                bad_req = req_write || req_region == cmsp_pkg::REGION_NONE; // [RULE8]
            end
            cmsp_pkg::SPACE_EXTERNAL_DATA: begin
                bad_req = req_region == cmsp_pkg::REGION_NONE; // [RULE10]
            end
            cmsp_pkg::SPACE_INTERNAL: begin
                bad_req = !req_indirect && req_addr[`CMSP_INT_UPPER_BIT]; // [RULE9]
            end
            cmsp_pkg::SPACE_SPECIAL_FUNCTION: begin
                bad_req = req_indirect
                    || (req_bit && (req_addr[2:0] & `CMSP_BIT_ALIGN_MASK) != 3'h0); // [RULE12]
            end
        endcase
    end

    // Sequencer, fetch and configuration state
    always_comb begin
        next_cur = cur;
        next_cur.fetch_valid = 1'b0;
        next_cur.rsp_valid = 1'b0;
        next_cur.rsp_err = 1'b0;
        next_cur.int_pend = 1'b0;
        req_ready = 1'b0;
        mem_en = 1'b0;
        mem_we = 1'b0;
        mem_addr = cur.pc;
        mem_wdata = 8'h00;
        int_en = 1'b0;
        int_we = 1'b0;
        int_special = req_space == cmsp_pkg::SPACE_SPECIAL_FUNCTION;
        int_bit = req_bit;
        int_bitpos = req_bitpos;
        int_wdata = req_wdata;
        // Internal data lands in the top SRAM page; special registers keep 7 bits
        int_addr = int_special ? {`CMSP_SPECIAL_BASE, req_addr[`CMSP_SPECIAL_AW-1:0]}
                               : {`CMSP_INT_PAGE, req_addr[7:0]}; // [RULE14] [RULE12]
        // Internal reads come back one cycle after the request
        if (cur.int_pend) begin
            next_cur.rsp_rdata = cur.int_pend_bit ? {7'h00, int_rdata[cur.int_pend_pos]}
                                                  : int_rdata;
        end
        if (sys_rst) begin
            next_cur.state = cmsp_pkg::ST_IDLE;
            next_cur.pc = `CMSP_RESET_PC; // [RULE5]
            next_cur.cnt = 3'h0;
            next_cur.rsp_rdata = 8'h00;
            next_cur.fetch_data = 8'h00;
            next_cur.gpio_oe_n = '1; // [RULE4]
            next_cur.gpio_pull = '1; // [RULE4]
            next_cur.wdt_en = 1'b0; // [RULE7]
        end else begin
            if (gpio_cfg_we) begin
                next_cur.gpio_oe_n = gpio_cfg_oe_n;
                next_cur.gpio_pull = gpio_cfg_pull;
            end
            if (wdt_enable_set) begin
                next_cur.wdt_en = 1'b1;
            end
            unique case (cur.state)
                cmsp_pkg::ST_IDLE: begin
                    req_ready = 1'b1;
                    // Bus is free: one fetch every clock, one byte per cycle
                    mem_en = 1'b1; // [RULE1] [RULE2]
                    next_cur.fetch_data = mem_rdata;
                    next_cur.fetch_valid = 1'b1;
                    next_cur.pc = cur.pc + 16'h0001; // [RULE1]
                    if (req_valid && bad_req) begin
                        next_cur.rsp_valid = 1'b1;
                        next_cur.rsp_err = 1'b1;
                    end else if (req_valid && (req_space == cmsp_pkg::SPACE_PROGRAM
                            || req_space == cmsp_pkg::SPACE_EXTERNAL_DATA)) begin
                        // Shared bus is claimed from the next cycle on
                        next_cur.state = cmsp_pkg::ST_BUSY; // [RULE11]
                        next_cur.cnt = `CMSP_EXT_CYCLES - 3'h1; // [RULE10]
                        next_cur.acc_addr = req_addr;
                        next_cur.acc_we = req_write;
                        next_cur.acc_wdata = req_wdata;
                    end else if (req_valid) begin
                        int_en = 1'b1;
                        int_we = req_write;
                        next_cur.int_pend = !req_write;
                        next_cur.int_pend_bit = req_bit;
                        next_cur.int_pend_pos = req_bitpos;
                        next_cur.rsp_valid = req_write;
                    end
                    if (cur.int_pend) begin
                        next_cur.rsp_valid = 1'b1;
                    end
                end
                cmsp_pkg::ST_BUSY: begin
                    // Fetch is held off while the data access owns the bus
                    mem_en = 1'b1; // [RULE11] [RULE16]
                    mem_addr = cur.acc_addr;
                    mem_wdata = cur.acc_wdata;
                    if (cur.cnt == 3'h0) begin
                        mem_we = cur.acc_we; // [RULE10]
                        next_cur.rsp_valid = 1'b1;
                        next_cur.rsp_rdata = cur.acc_we ? 8'h00 : mem_rdata;
                        next_cur.state = cmsp_pkg::ST_IDLE; // [RULE16]
                    end else begin
                        next_cur.cnt = cur.cnt - 3'h1;
                    end
                end
            endcase
            // A taken jump overrides the sequential address, stalled or not
            if (pc_load) begin
                next_cur.pc = pc_target;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        cur <= next_cur;
    end

    // Outputs
    assign mem_region = region_of(mem_addr);
    assign periph_rst = sys_rst; // [RULE6]
    assign wdt_en = cur.wdt_en;
    assign gpio_oe_n = cur.gpio_oe_n;
    assign gpio_pull = cur.gpio_pull;
    assign pc = cur.pc;
    assign fetch_valid = cur.fetch_valid;
    assign fetch_data = cur.fetch_data;
    assign rsp_valid = cur.rsp_valid;
    assign rsp_err = cur.rsp_err;
    assign rsp_rdata = cur.rsp_rdata;
endmodule
`default_nettype wire

//--- rtl/cmsp_pkg.sv
// Types shared by the core reset and memory space block
`default_nettype none
package cmsp_pkg;

    // Address space selected by a core data request
    typedef enum logic [1:0] {
        SPACE_PROGRAM,
        SPACE_INTERNAL,
        SPACE_EXTERNAL_DATA,
        SPACE_SPECIAL_FUNCTION
    } cmsp_space_t;

    // Physical memory reached over the shared bus
    typedef enum logic [1:0] {
        REGION_NONE,
        REGION_FLASH,
        REGION_PERIPH,
        REGION_SRAM
    } cmsp_region_t;

    // Shared bus sequencer
    typedef enum logic {
        ST_IDLE,
        ST_BUSY
    } cmsp_state_t;

endpackage
`default_nettype wire

//--- rtl/cmsp_rst_gen.sv
// Combined reset generator for power-on, reset pin and watchdog sources
`include "cmsp_consts.svh"
`default_nettype none
module cmsp_rst_gen (
    // Clock and power-on reset
    input wire logic mclk,
    input wire logic rst,
    // Reset sources
    input wire logic reset_n,
    input wire logic wdt_timeout,
    // Combined reset and its last cause
    output logic sys_rst,
    output logic [1:0] rst_cause
);
    typedef struct packed {
        logic active;
        logic [3:0] hold;
        logic [1:0] cause;
    } cmsp_rst_state_t;

    cmsp_rst_state_t cur;
    cmsp_rst_state_t next_cur;

    // Any source restarts the stretch so short glitches still give a full reset
    always_comb begin
        next_cur = cur;
        if (rst) begin
            next_cur.active = 1'b1;
            next_cur.hold = `CMSP_RST_HOLD;
            next_cur.cause = `CMSP_CAUSE_POWER; // [RULE3]
        end else if (!reset_n) begin
            next_cur.active = 1'b1;
            next_cur.hold = `CMSP_RST_HOLD;
            next_cur.cause = `CMSP_CAUSE_PIN; // [RULE3]
        end else if (wdt_timeout) begin
            next_cur.active = 1'b1;
            next_cur.hold = `CMSP_RST_HOLD;
            next_cur.cause = `CMSP_CAUSE_WATCHDOG; // [RULE3]
        end else if (cur.hold != 4'h0) begin
            next_cur.hold = cur.hold - 4'h1;
        end else begin
            next_cur.active = 1'b0;
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        cur <= next_cur;
    end

    assign sys_rst = cur.active | rst;
    assign rst_cause = cur.cause;
endmodule
`default_nettype wire

//--- sim/cmsp_core_mem_assertions.sv
// Checker module and bind for the core reset and memory space block
`include "cmsp_consts.svh"
`default_nettype none
module cmsp_core_mem_assertions #(
    parameter logic [127:0] CORE_INTERNAL_MASK = 128'h0
) (
    // Clock and reset sources
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_n,
    input wire logic wdt_timeout,
    input wire logic wdt_en,
    input wire logic periph_rst,
    // Fetch
    input wire logic pc_load,
    input wire logic [15:0] pc,
    input wire logic fetch_valid,
    // Requests
    input wire logic req_valid,
    input wire cmsp_pkg::cmsp_space_t req_space,
    input wire logic req_write,
    input wire logic req_indirect,
    input wire logic req_bit,
    input wire logic [2:0] req_bitpos,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic rsp_err,
    // Buses
    input wire logic mem_en,
    input wire logic [15:0] mem_addr,
    input wire cmsp_pkg::cmsp_region_t mem_region,
    input wire logic int_en,
    input wire logic int_we,
    input wire logic int_special,
    input wire logic int_bit,
    input wire logic [2:0] int_bitpos,
    input wire logic [7:0] int_wdata,
    input wire logic [15:0] int_addr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    // Request decode; only the three real regions count, core-internal registers have no mirror
    wire logic take = req_valid && req_ready;
    wire logic intl = req_space == cmsp_pkg::SPACE_INTERNAL;
    wire logic sfs = req_space == cmsp_pkg::SPACE_SPECIAL_FUNCTION;
    wire logic mapped = req_addr <= `CMSP_FLASH_HI || req_addr >= `CMSP_SRAM_LO
        || (req_addr >= `CMSP_PERIPH_LO && req_addr <= `CMSP_PERIPH_HI
        && !CORE_INTERNAL_MASK[req_addr[6:0]]);
    wire logic shared = req_space == cmsp_pkg::SPACE_EXTERNAL_DATA
        || (req_space == cmsp_pkg::SPACE_PROGRAM && !req_write);
    // A shared-bus access: taken, four busy cycles, then a clean answer
    sequence s_shared_take;
        take && mapped && shared;
    endsequence
    sequence s_shared_busy;
        (mem_en && !req_ready) [*4] ##1 (rsp_valid && !rsp_err);
    endsequence
    property p_pin_rst; !reset_n |=> periph_rst; endproperty
    a_pin_rst: assert property (p_pin_rst) else $error("pin reset not taken");
    property p_wdt_off; wdt_timeout && !wdt_en && reset_n && !periph_rst
        |=> !periph_rst; endproperty
    a_wdt_off: assert property (p_wdt_off) else $error("disabled watchdog reset");
    property p_pc_start; $fell(periph_rst)
        |-> pc == `CMSP_RESET_PC && mem_en && mem_addr == pc; endproperty
    a_pc_start: assert property (p_pc_start) else $error("bad start address");
    property p_fetch; req_ready && !req_valid && !pc_load |-> mem_en && mem_addr == pc
        ##1 fetch_valid && pc == $past(pc) + 16'h0001; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch not one per clock");
    property p_shared; s_shared_take |=> s_shared_busy; endproperty
    a_shared: assert property (p_shared) else $error("shared access timing");
    property p_no_prefetch; s_shared_take |-> ##2 !fetch_valid [*4]; endproperty
    a_no_prefetch: assert property (p_no_prefetch) else $error("prefetch overlap");
    property p_prog_ro; take && !shared && !intl && !sfs |=> rsp_valid && rsp_err; endproperty
    a_prog_ro: assert property (p_prog_ro) else $error("program write accepted");
    property p_int_upper; take && intl && !req_indirect && req_addr[7] |=> rsp_err; endproperty
    a_int_upper: assert property (p_int_upper) else $error("direct upper accepted");
    property p_sfs_err; take && sfs && (req_indirect || (req_bit && req_addr[2:0] != 3'h0))
        |=> rsp_valid && rsp_err; endproperty
    a_sfs_err: assert property (p_sfs_err) else $error("special access accepted");
    property p_int_map; take && intl && (req_indirect || !req_addr[7])
        |-> int_addr == {`CMSP_INT_PAGE, req_addr[7:0]}; endproperty
    a_int_map: assert property (p_int_map) else $error("internal address map");
    // A legal internal write goes straight out on the internal port
    property p_int_wr; take && intl && req_write && (req_indirect || !req_addr[7])
        |-> int_en && int_we && int_wdata == req_wdata; endproperty
    a_int_wr: assert property (p_int_wr) else $error("internal write lost");
    property p_sfs_map; take && sfs && !req_indirect |-> int_special && int_bit == req_bit
        && int_bitpos == req_bitpos && int_addr == {`CMSP_SPECIAL_BASE, req_addr[6:0]};
    endproperty
    a_sfs_map: assert property (p_sfs_map) else $error("special address map");
    property p_region; mem_en
        |-> (mem_addr >= `CMSP_SRAM_LO) == (mem_region == cmsp_pkg::REGION_SRAM)
        && (mem_addr <= `CMSP_FLASH_HI) == (mem_region == cmsp_pkg::REGION_FLASH); endproperty
    a_region: assert property (p_region) else $error("region decode");
endmodule
bind cmsp_core_mem cmsp_core_mem_assertions #(.CORE_INTERNAL_MASK(CORE_INTERNAL_MASK))
    u_chk (.*);
`default_nettype wire

//--- sim/cmsp_core_mem_tb_top.sv
// Self-checking bench for the core reset and memory space block
`include "cmsp_consts.svh"
`default_nettype none
`define CMSP_CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module cmsp_core_mem_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int GPIO_W = 21;
    // Register 6 hidden from the mirror so the core-internal exception is exercised
    localparam logic [127:0] CORE_INTERNAL_MASK = 128'h40;
    localparam cmsp_pkg::cmsp_space_t sp_prg = cmsp_pkg::SPACE_PROGRAM;
    localparam cmsp_pkg::cmsp_space_t sp_int = cmsp_pkg::SPACE_INTERNAL;
    localparam cmsp_pkg::cmsp_space_t sp_ext = cmsp_pkg::SPACE_EXTERNAL_DATA;
    localparam cmsp_pkg::cmsp_space_t sp_sfs = cmsp_pkg::SPACE_SPECIAL_FUNCTION;
    int err_total = 0;
    int n_compared = 0;
    int lat;
    logic mclk = 1'h0, rst = 1'h1, reset_n = 1'h1, wdt_timeout = 1'h0, wdt_enable_set = 1'h0;
    logic gpio_cfg_we = 1'h0, pc_load = 1'h0, req_valid = 1'h0, req_write = 1'h0;
    logic req_indirect = 1'h0, req_bit = 1'h0;
    logic [2:0] req_bitpos = 3'h0;
    logic [7:0] req_wdata = 8'h00;
    logic [15:0] pc_target = 16'h0000, req_addr = 16'h0000;
    logic [GPIO_W-1:0] gpio_cfg_oe_n = {GPIO_W{1'h1}}, gpio_cfg_pull = {GPIO_W{1'h1}};
    cmsp_pkg::cmsp_space_t req_space = cmsp_pkg::SPACE_PROGRAM;
    logic wdt_en, periph_rst, fetch_valid, req_ready, rsp_valid, rsp_err, mem_en, mem_we;
    logic int_en, int_we, int_special, int_bit;
    logic [1:0] rst_cause;
    logic [2:0] int_bitpos;
    logic [GPIO_W-1:0] gpio_oe_n, gpio_pull;
    logic [15:0] pc, mem_addr, int_addr;
    logic [7:0] fetch_data, rsp_rdata, mem_wdata, mem_rdata, int_wdata, int_rdata;
    cmsp_pkg::cmsp_region_t mem_region;
    cmsp_core_mem #(.GPIO_W(GPIO_W), .CORE_INTERNAL_MASK(CORE_INTERNAL_MASK)) dut (.*);
    cmsp_mem_model u_mem (.*);
    // 200 MHz clock
    always #2.5 mclk = ~mclk;
    // Sampling point just after an edge, once its updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Waits for the combined reset to clear, then checks the state it left
    task automatic chk_reset(input logic [1:0] cause);
        for (int i = 0; i < 40 && periph_rst !== 1'h0; i++) tick(1);
        `CMSP_CHK("rst end", 1'h0, periph_rst)
        `CMSP_CHK("cause", cause, rst_cause)
        `CMSP_CHK("pc", `CMSP_RESET_PC, pc)
        `CMSP_CHK("oe_n", {GPIO_W{1'h1}}, gpio_oe_n)
        `CMSP_CHK("pull", {GPIO_W{1'h1}}, gpio_pull)
        `CMSP_CHK("wdt_en", 1'h0, wdt_en)
    endtask
    // One request held until taken; f is {write, indirect, bit, bitpos}
    task automatic xfer(input cmsp_pkg::cmsp_space_t sp, input logic [5:0] f,
            input logic [15:0] ad, input logic [7:0] wd, input logic er, input logic [7:0] rd);
        @(posedge mclk);
        {req_valid, req_space, req_write, req_indirect, req_bit, req_bitpos} <= {1'h1, sp, f};
        {req_addr, req_wdata} <= {ad, wd};
        for (int i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (req_ready === 1'h1) break;
        end
        `CMSP_CHK("ready", 1'h1, req_ready)
        req_valid <= 1'h0;
        #1;
        for (lat = 0; lat < 10 && rsp_valid !== 1'h1; lat++) tick(1);
        `CMSP_CHK("rsp_valid", 1'h1, rsp_valid)
        `CMSP_CHK("rsp_err", er, rsp_err)
        if (!er && !f[5] && f[3]) `CMSP_CHK("rbit", rd, rsp_rdata)
        if (!er && !f[5] && !f[3]) `CMSP_CHK("rdata", rd, rsp_rdata)
    endtask
    // Back-to-back fetches from the reset address, one byte per clock
    task automatic t_fetch;
        for (int i = 0; i < 4; i++) begin
            tick(1);
            `CMSP_CHK("fv", 1'h1, fetch_valid)
            `CMSP_CHK("fetch", 8'hA5 ^ 8'(i), fetch_data)
        end
        // A jump redirects the stream; the byte at the target follows one clock later
        @(posedge mclk);
        {pc_load, pc_target} <= {1'h1, 16'hF012};
        @(posedge mclk);
        pc_load <= 1'h0;
        tick(1);
        `CMSP_CHK("jump pc", 16'hF013, pc)
        `CMSP_CHK("jump fetch", 8'hB7, fetch_data)
    endtask
    // Every space, legal and refused accesses, overlap through the shared bus
    task automatic t_mem;
        xfer(sp_ext, 6'h20, 16'hF010, 8'h3C, 1'h0, 8'h00);
        xfer(sp_ext, 6'h00, 16'hF010, 8'h00, 1'h0, 8'h3C);
        `CMSP_CHK("ext lat", 4, lat)
        xfer(sp_prg, 6'h00, 16'hF010, 8'h00, 1'h0, 8'h3C);
        xfer(sp_prg, 6'h20, 16'h0100, 8'h55, 1'h1, 8'h00);
        xfer(sp_ext, 6'h00, 16'h8000, 8'h00, 1'h1, 8'h00);
        xfer(sp_ext, 6'h00, 16'hDF85, 8'h00, 1'h0, 8'h20);
        xfer(sp_ext, 6'h00, 16'hDF86, 8'h00, 1'h1, 8'h00);
        xfer(sp_int, 6'h00, 16'h0005, 8'h00, 1'h0, 8'hFA);
        xfer(sp_int, 6'h00, 16'h0085, 8'h00, 1'h1, 8'h00);
        xfer(sp_int, 6'h10, 16'h0085, 8'h00, 1'h0, 8'h7A);
        xfer(sp_int, 6'h20, 16'h0007, 8'h99, 1'h0, 8'h00);
        xfer(sp_sfs, 6'h0B, 16'h0010, 8'h00, 1'h0, 8'h01);
        xfer(sp_sfs, 6'h00, 16'h0011, 8'h00, 1'h0, 8'h6E);
        xfer(sp_sfs, 6'h10, 16'h0011, 8'h00, 1'h1, 8'h00);
        xfer(sp_sfs, 6'h08, 16'h0011, 8'h00, 1'h1, 8'h00);
    endtask
    // Pins set to outputs, then the reset pin must undo it
    task automatic t_pin;
        @(posedge mclk);
        {gpio_cfg_we, gpio_cfg_oe_n, gpio_cfg_pull} <= {1'h1, {2 * GPIO_W{1'h0}}};
        @(posedge mclk);
        {gpio_cfg_we, reset_n} <= 2'h0;
        tick(1);
        `CMSP_CHK("oe cfg", {GPIO_W{1'h0}}, gpio_oe_n)
        `CMSP_CHK("prst", 1'h1, periph_rst)
        @(posedge mclk);
        reset_n <= 1'h1;
        chk_reset(`CMSP_CAUSE_PIN);
    endtask
    // Timeout ignored while disabled, honoured once enabled
    task automatic t_wdt;
        @(posedge mclk);
        wdt_timeout <= 1'h1;
        @(posedge mclk);
        {wdt_timeout, wdt_enable_set} <= 2'h1;
        @(posedge mclk);
        wdt_enable_set <= 1'h0;
        tick(1);
        `CMSP_CHK("ignored", 1'h0, periph_rst)
        `CMSP_CHK("wdt_en", 1'h1, wdt_en)
        @(posedge mclk);
        wdt_timeout <= 1'h1;
        @(posedge mclk);
        wdt_timeout <= 1'h0;
        tick(1);
        `CMSP_CHK("wdt rst", 1'h1, periph_rst)
        chk_reset(`CMSP_CAUSE_WATCHDOG);
    endtask
    // Verdict and end of run
    task automatic results;
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Main sequence after the power-on reset
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'h0;
        chk_reset(`CMSP_CAUSE_POWER);
        t_fetch();
        t_mem();
        t_pin();
        t_wdt();
        results();
    end
    // The sequence needs about a hundred cycles; this 4000-cycle limit cuts a hang short
    initial begin
        #20000;
        err_total++;
        results();
    end
endmodule
`default_nettype wire

//--- sim/cmsp_mem_model.sv
// Behavioural model of the memories behind the shared bus and internal port
`default_nettype none
module cmsp_mem_model (
    // Clock
    input wire logic mclk,
    // Shared bus
    input wire logic mem_en,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata,
    // Internal port
    input wire logic int_en,
    input wire logic [15:0] int_addr,
    output logic [7:0] int_rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'hA5;
    initial int_rdata = 8'h00;
    // Deselected bus shows the inverse of its last value so a stale read never matches
    assign mem_rdata = mem_en ? mem[mem_addr[7:0]] : ~last;
    // All regions fold onto one array, so mirrored addresses alias
    always @(posedge mclk) begin
        if (mem_en) last <= mem[mem_addr[7:0]];
        if (mem_en && mem_we) mem[mem_addr[7:0]] <= mem_wdata;
        int_rdata <= int_en ? ~int_addr[7:0] : ~int_rdata; // Toggles while deselected
    end
endmodule
`default_nettype wire
